//--- common/smiip_pkg.sv
// Shared constants for the PHY-side serial MII segment engine.
// Assumes a 50 MHz system clock that oversamples a much slower link clock.
package smiip_pkg;
    localparam int SEG_BITS      = 10;
    localparam int REPEAT_10M    = 10;
    localparam int SEG_CNT_W     = 4;
    // Bit positions within a segment, in serial order
    localparam int POS_FLAG0     = 0;
    localparam int POS_FLAG1     = 1;
    localparam int POS_DATA      = 2;
    // Status byte positions when valid is low
    localparam int ST_RXERR      = 0;
    localparam int ST_SPEED      = 1;
    localparam int ST_DUPLEX     = 2;
    localparam int ST_LINK       = 3;
    localparam int ST_JABBER     = 4;
    localparam int ST_NIBBLE     = 5;
    localparam int ST_FALSE_CRS  = 6;
    localparam int ST_ONE        = 7;
    localparam logic [2:0] CFG_SERIAL = 3'h0_2;
    localparam logic [3:0] CNT_ZERO   = 4'h0_0;
    localparam logic [7:0] BYTE_ZERO  = 8'h00_00;
endpackage

//--- hdl/smiip_shift.sv
// Ten-bit segment shifter used for the transmit direction only.
// Assumes the caller supplies a one-cycle bit strobe and segment start.
`timescale 1ns/10ps
module smiip_shift #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             step,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             ser_in,
    output logic      [WIDTH-1:0] par_out,
    output logic                  ser_out
);
    generate
        if (WIDTH < 2) begin
            $error("smiip_shift: WIDTH too small");
        end
    endgenerate

    typedef struct packed {
        logic [WIDTH-1:0] sh;
    } smiip_shift_state_type;

    smiip_shift_state_type st_q;
    smiip_shift_state_type st_d;

    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.sh = load_val;
        end else if (step) begin
            st_d.sh = {ser_in, st_q.sh[WIDTH-1:1]};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign par_out = st_q.sh;
    assign ser_out = st_q.sh[0];
endmodule

//--- hdl/smiip_phy.sv
// PHY end of a serial MII link: frames ten-bit segments on tx and rx.
// Assumes link clock, sync and tx pins are asynchronous to clk and slow
// enough to be edge-detected after a two-stage synchroniser.
`timescale 1ns/10ps
// Overview of operation
// - Every segment is exactly ten bits starting at sync.
// - At 10M each transmit segment repeats tenfold; take one copy.
// - At 10M each receive segment is sent ten times.
// - At 100M every segment carries a new byte.
// - Receive segment holds carrier, valid and eight data bits, or eight status bits when valid is low.
module smiip_phy (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       link_clk,
    input  wire logic       sync,
    input  wire logic       tx_pin,
    output logic            rx_pin,
    input  wire logic [2:0] mode_strap,
    output logic            serial_mode,
    input  wire logic       speed_100,
    input  wire logic       full_duplex,
    input  wire logic       link_up,
    input  wire logic       jabber,
    input  wire logic       nibble_ok,
    input  wire logic       false_carrier,
    input  wire logic       prev_rx_err,
    input  wire logic       rx_crs,
    input  wire logic       rx_dv,
    input  wire logic [7:0] rx_byte,
    output logic            rx_take,
    output logic            tx_valid,
    output logic            tx_en,
    output logic            tx_err,
    output logic [7:0]      tx_byte
);
    localparam int N = smiip_pkg::SEG_BITS;

    typedef enum logic [2:0] {
        S_HUNT = 3'h0_1,
        S_RUN  = 3'h0_2,
        S_OFF  = 3'h0_4
    } smiip_fsm_type;

    typedef struct packed {
        logic [2:0]          s_lc;
        logic [2:0]          s_sy;
        logic [2:0]          s_tx;
        logic                lc_old;
        smiip_fsm_type       fsm;
        logic [3:0]          bit_cnt;
        logic [3:0]          rep_cnt;
        logic                mode;
        logic                strap_done;
        logic [N-1:0]        rx_seg;
        logic [N-1:0]        rx_hold;
        logic                out_bit;
        logic                txv;
        logic                txe;
        logic                txr;
        logic [7:0]          txb;
    } smiip_state_type;

    smiip_state_type st_q;
    smiip_state_type st_d;

    logic          lc_rise;
    logic          sync_s;
    logic          tx_s;
    logic          seg_start;
    logic          seg_end;
    logic [N-1:0]  tx_par;
    logic [N-1:0]  tx_now;
    logic [N-1:0]  rx_cur;
    logic [N-1:0]  rx_load;
    logic [7:0]    status_byte;
    logic          rx_ser;

    // Stage 0 of each synchroniser feeds only stage 1
    assign lc_rise = st_q.s_lc[1] & ~st_q.lc_old;
    assign sync_s  = st_q.s_sy[1];
    assign tx_s    = st_q.s_tx[1];
    assign seg_start = lc_rise & sync_s;

    always_comb begin
        status_byte = smiip_pkg::BYTE_ZERO;
        status_byte[smiip_pkg::ST_RXERR]     = prev_rx_err;
        status_byte[smiip_pkg::ST_SPEED]     = speed_100;
        status_byte[smiip_pkg::ST_DUPLEX]    = full_duplex;
        status_byte[smiip_pkg::ST_LINK]      = link_up;
        status_byte[smiip_pkg::ST_JABBER]    = jabber;
        status_byte[smiip_pkg::ST_NIBBLE]    = nibble_ok;
        status_byte[smiip_pkg::ST_FALSE_CRS] = false_carrier;
        status_byte[smiip_pkg::ST_ONE]       = 1'b1;
    end

    // Segment in serial order: carrier, valid, then byte lsb first
    assign rx_load = {(rx_dv ? rx_byte : status_byte), rx_dv, rx_crs};

    smiip_shift #(
        .WIDTH (N)
    ) u_tx_shift (
        .clk      (clk),
        .srst     (srst),
        .step     (lc_rise),
        .load     (1'b0),
        .load_val ('0),
        .ser_in   (tx_s),
        .par_out  (tx_par),
        .ser_out  ()
    );

    // Last bit of the segment has been shifted in on this edge
    assign seg_end = lc_rise && (st_q.fsm == S_RUN)
                     && (st_q.bit_cnt == 4'(N - 1));

    // Whole segment once the tenth bit is in, bit 0 at the bottom
    assign tx_now = {tx_s, tx_par[N-1:1]};

    // A new receive byte per segment at 100M, per tenth segment at 10M
    assign rx_take = seg_start && (st_q.fsm != S_OFF)
                     && (speed_100
                         || st_q.rep_cnt == smiip_pkg::CNT_ZERO);
    // Group copies come from the held segment, so inputs that move
    // inside a 10M group cannot leak onto the line
    assign rx_cur = rx_take ? rx_load : st_q.rx_hold;

    always_comb begin
        st_d        = st_q;
        rx_ser      = 1'b0;
        st_d.s_lc   = {st_q.s_lc[1:0], link_clk};
        st_d.s_sy   = {st_q.s_sy[1:0], sync};
        st_d.s_tx   = {st_q.s_tx[1:0], tx_pin};
        st_d.lc_old = st_q.s_lc[1];
        st_d.txv    = 1'b0;
        if (!st_q.strap_done) begin
            st_d.strap_done = 1'b1;
            st_d.mode = (mode_strap == smiip_pkg::CFG_SERIAL);
        end
        case (st_q.fsm)
            S_HUNT: begin
                if (st_q.strap_done && !st_q.mode) begin
                    st_d.fsm = S_OFF;
                end else if (seg_start) begin
                    st_d.fsm     = S_RUN;
                    st_d.bit_cnt = 4'h0_1;
                end
            end
            S_RUN: begin
                if (lc_rise) begin
                    if (seg_start) begin
                        // Resync on every pulse, not only at count wrap
                        st_d.bit_cnt = 4'h0_1;
                    end else if (st_q.bit_cnt == 4'(N - 1)) begin
                        st_d.bit_cnt = smiip_pkg::CNT_ZERO;
                    end else begin
                        st_d.bit_cnt = st_q.bit_cnt + 4'h0_1;
                    end
                end
            end
            S_OFF: begin
                st_d.fsm = S_OFF;
            end
            default: begin
                st_d.fsm = S_HUNT;
            end
        endcase
        // Receive segment loaded at sync, then shifted out
        if (lc_rise && st_q.fsm != S_OFF) begin
            if (seg_start) begin
                st_d.out_bit = rx_cur[0];
                st_d.rx_seg  = {1'b0, rx_cur[N-1:1]};
                if (rx_take) begin
                    st_d.rx_hold = rx_load;
                end
                if (!speed_100) begin
                    if (st_q.rep_cnt == 4'(smiip_pkg::REPEAT_10M - 1)) begin
                        st_d.rep_cnt = smiip_pkg::CNT_ZERO;
                    end else begin
                        st_d.rep_cnt = st_q.rep_cnt + 4'h0_1;
                    end
                end else begin
                    st_d.rep_cnt = smiip_pkg::CNT_ZERO;
                end
            end else begin
                st_d.out_bit = st_q.rx_seg[0];
                st_d.rx_seg  = {1'b0, st_q.rx_seg[N-1:1]};
            end
        end
        if (seg_end) begin
            // Take the first copy of each 10M group
            if (speed_100 || st_q.rep_cnt == 4'h0_1) begin
                st_d.txv = 1'b1;
                st_d.txr = tx_now[smiip_pkg::POS_FLAG0];
                st_d.txe = tx_now[smiip_pkg::POS_FLAG1];
                st_d.txb = tx_now[N-1:smiip_pkg::POS_DATA];
            end
        end
        rx_ser = st_q.out_bit;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q     <= '0;
            st_q.fsm <= S_HUNT;
        end else begin
            st_q <= st_d;
        end
    end

    assign rx_pin      = rx_ser;
    assign serial_mode = st_q.mode;
    assign tx_valid    = st_q.txv;
    assign tx_en       = st_q.txe;
    assign tx_err      = st_q.txr;
    assign tx_byte     = st_q.txb;

    sequence seg_begin_s;
        st_q.fsm == S_RUN && lc_rise && sync_s;
    endsequence

    seg_count_a: assert property (@(posedge clk) disable iff (srst)
        seg_begin_s |=> st_q.bit_cnt == 4'h0_1)
        else $error("bit count not restarted at sync");

    rep_wrap_a: assert property (@(posedge clk) disable iff (srst)
        st_q.rep_cnt <= 4'(smiip_pkg::REPEAT_10M - 1))
        else $error("repeat counter out of range");

    fast_take_a: assert property (@(posedge clk) disable iff (srst)
        (speed_100 && st_q.fsm != S_OFF && lc_rise && sync_s) |-> rx_take)
        else $error("100M segment did not take a byte");

    idle_one_a: assert property (@(posedge clk) disable iff (srst)
        (rx_take && !rx_dv) |=> st_q.rx_seg[N-2])
        else $error("status top bit not one");

    rep_hold_a: assert property (@(posedge clk) disable iff (srst)
        (seg_start && st_q.fsm != S_OFF && !rx_take)
        |=> st_q.out_bit == $past(st_q.rx_hold[0]))
        else $error("repeated receive segment changed");

    load_fmt_a: assert property (@(posedge clk) disable iff (srst)
        rx_load[smiip_pkg::POS_FLAG1] == rx_dv)
        else $error("valid bit misplaced");

    strap_mode_a: assert property (@(posedge clk) disable iff (srst)
        st_q.fsm == S_OFF |-> !st_q.mode)
        else $error("serial mode off while strap matched");

    tx_pulse_a: assert property (@(posedge clk) disable iff (srst)
        tx_valid |=> !tx_valid)
        else $error("transmit strobe longer than a cycle");

    tx_field_a: assert property (@(posedge clk) disable iff (srst)
        tx_valid |-> tx_byte == $past(tx_now[N-1:smiip_pkg::POS_DATA]))
        else $error("transmit byte mismatch");
endmodule

//--- tb/smiip_mac_model.sv
// Behavioural serial MII MAC facing the PHY block.
// Assumes the bench supplies the transmit segment and reads back rx_seg.
`timescale 1ns/10ps
module smiip_mac_model (
    input  wire logic       rx_pin,
    input  wire logic [9:0] tx_seg,
    output logic            link_clk,
    output logic            sync,
    output logic            tx_pin,
    output logic            col,
    output logic [9:0]      rx_seg,
    output int              n_rx
);
    logic [8:0] part_q;
    int         pos;
    assign col = rx_seg[0] & tx_seg[1];
    initial begin
        link_clk = 1'h0;
        sync = 1'h0;
        tx_pin = 1'h0;
        rx_seg = 10'h000;
        n_rx = 0;
        pos = 0;
        part_q = 9'h000;
        // Odd offset keeps the link clock out of phase with clk
        #7;
        forever #80 link_clk = ~link_clk;
    end
    // Bit k of the PHY stands until after the next rise, so read it there
    always @(posedge link_clk) begin
        if (pos != 0) begin
            part_q[pos-1] <= rx_pin;
        end else begin
            rx_seg <= {rx_pin, part_q};
            n_rx   <= n_rx + 1;
        end
        pos <= (pos == 9) ? 0 : pos + 1;
    end
    // Launch on the fall so each bit is settled at the sampled rise
    always @(negedge link_clk) begin
        sync   <= (pos == 0);
        tx_pin <= tx_seg[pos];
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the PHY end of the serial MII link.
// Assumes the MAC model above on the serial side.
`timescale 1ns/10ps
module testbench;
    logic       clk, srst, rx_pin, serial_mode, rx_take, tx_valid;
    logic       tx_en, tx_err, link_clk, sync, tx_pin, rx_crs, rx_dv;
    logic [2:0] mode_strap;
    logic [6:0] st;
    logic [7:0] rx_byte, tx_byte;
    logic [9:0] tx_seg, rx_seg;
    int         n_rx, n_fail, total_checks, n_tv, n_rt;
    smiip_phy u_dut (.clk(clk), .srst(srst), .link_clk(link_clk),
        .sync(sync), .tx_pin(tx_pin), .rx_pin(rx_pin),
        .mode_strap(mode_strap), .serial_mode(serial_mode),
        .speed_100(st[1]), .full_duplex(st[2]), .link_up(st[3]),
        .jabber(st[4]), .nibble_ok(st[5]), .false_carrier(st[6]),
        .prev_rx_err(st[0]), .rx_crs(rx_crs), .rx_dv(rx_dv),
        .rx_byte(rx_byte), .rx_take(rx_take), .tx_valid(tx_valid),
        .tx_en(tx_en), .tx_err(tx_err), .tx_byte(tx_byte));
    smiip_mac_model u_mac (.rx_pin(rx_pin), .tx_seg(tx_seg),
        .link_clk(link_clk), .sync(sync), .tx_pin(tx_pin), .col(),
        .rx_seg(rx_seg), .n_rx(n_rx));
    always #10 clk = ~clk;
    task results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task do_reset(input logic [2:0] strap);
        @(posedge clk);
        srst <= 1'h1;
        mode_strap <= strap;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    // One segment is ten link clocks, exactly 80 system clocks
    task count(input int segs);
        n_tv = 0;
        n_rt = 0;
        repeat (segs * 80) begin
            @(negedge clk);
            if (tx_valid === 1'h1) n_tv++;
            if (rx_take === 1'h1) n_rt++;
        end
    endtask
    task wait_pulse(input bit rx_side);
        for (int i = 0; i < 1000; i++) begin
            @(negedge clk);
            if ((rx_side ? rx_take : tx_valid) === 1'h1) return;
        end
        n_fail++;
        $display("CHECK FAILED pulse wait expected 1 seen 0");
        results;
    endtask
    task t_strap_off;
        do_reset(3'h1);
        chk("serial_mode", 10'h000, {9'h000, serial_mode});
        count(10);
        chk("tx_valid count", 10'h000, 10'(n_tv));
        chk("rx segment", 10'h000, rx_seg);
    endtask
    task tx_case(input logic [9:0] val);
        @(posedge clk);
        tx_seg <= val;
        wait_pulse(1'b0);
        wait_pulse(1'b0);
        chk("tx segment", val, {tx_byte, tx_en, tx_err});
    endtask
    task t_tx100;
        do_reset(3'h2);
        chk("serial_mode", 10'h001, {9'h000, serial_mode});
        tx_case({8'ha5, 1'h1, 1'h0});
        tx_case({8'heb, 1'h0, 1'h1});
        count(10);
        chk("tx_valid count 100M", 10'h00a, 10'(n_tv));
    endtask
    task t_rx100;
        @(posedge clk);
        rx_crs <= 1'h1;
        rx_dv <= 1'h1;
        rx_byte <= 8'h3c;
        count(3);
        chk("rx data segment", {8'h3c, 1'h1, 1'h1}, rx_seg);
        @(posedge clk);
        rx_crs <= 1'h0;
        rx_dv <= 1'h0;
        count(10);
        chk("rx status segment", {8'hab, 1'h0, 1'h0}, rx_seg);
        chk("rx_take count 100M", 10'h00a, 10'(n_rt));
    endtask
    task t_10m;
        @(posedge clk);
        st[1] <= 1'h0;
        tx_seg <= {8'h5a, 1'h1, 1'h0};
        rx_dv <= 1'h1;
        count(10);
        count(30);
        chk("tx_valid count 10M", 10'h003, 10'(n_tv));
        chk("rx_take count 10M", 10'h003, 10'(n_rt));
        chk("tx byte 10M", {8'h5a, 1'h1, 1'h0}, {tx_byte, tx_en, tx_err});
    endtask
    // New byte moves inside a 10M group: the group must keep the old one
    task t_rx_hold;
        @(posedge clk);
        rx_byte <= 8'h11;
        count(10);
        wait_pulse(1'b1);
        @(posedge clk);
        rx_byte <= 8'h22;
        count(5);
        chk("rx held 10M", {8'h11, 1'h1, 1'h0}, rx_seg);
        count(10);
        chk("rx next group 10M", {8'h22, 1'h1, 1'h0}, rx_seg);
    endtask
    initial begin
        clk = 1'h0;
        srst = 1'h1;
        mode_strap = 3'h2;
        st = 7'h2b;
        rx_crs = 1'h1;
        rx_dv = 1'h1;
        rx_byte = 8'hff;
        tx_seg = 10'h3fe;
        n_fail = 0;
        total_checks = 0;
        t_strap_off;
        t_tx100;
        t_rx100;
        t_10m;
        t_rx_hold;
        results;
    end
endmodule
